/* pwr_mode_ctrl.sv */
// power reduction mode controller: idle and power down entry, wake and clock control
//
// Implementation choices: the register addresses and register access over APB.
`default_nettype none
module pwr_mode_ctrl (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side, same clock
  input wire logic idle_instr,
  input wire logic clock_stop_instruction,
  input wire logic return_from_interrupt,
  input wire logic irq_request,
  input wire logic rtc_irq,
  input wire logic can_i2c_irq,
  // external bus controller, same clock
  input wire logic bus_pending,
  input wire logic bus_access_active,
  input wire logic bus_access_done,
  // device pins, asynchronous
  input wire logic ready_pin,
  input wire logic nmi_pin_n,
  input wire logic reset_input_pin_n,
  input wire logic [pwr_mode_pkg::NUM_FAST_IRQ-1:0] fast_external_interrupt_input,
  input wire logic lp_osc_running,
  // power control outputs
  output logic cpu_halt,
  output logic periph_clk_stop,
  output logic wdt_hold,
  output logic main_osc_stop,
  output logic rtc_ref_lp,
  output logic regulator_off,
  output logic pd_wake
);
  import pwr_mode_pkg::*;

  logic ready_s;
  logic nmi_s_n;
  logic rstpin_s_n;
  logic lposc_s;
  logic [NUM_FAST_IRQ-1:0] fast_s;

  pin_sync #(
    .WIDTH(NUM_FAST_IRQ + 4),
    .INIT({{NUM_FAST_IRQ{1'b0}}, 4'h6})
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({fast_external_interrupt_input, ready_pin, nmi_pin_n,
      reset_input_pin_n, lp_osc_running}),
    .sync_out({fast_s, ready_s, nmi_s_n, rstpin_s_n, lposc_s})
  );

  // registers
  logic [7:0] system_config_register_reg;
  logic [2:0] misc_control_register_reg;
  logic [15:0] fastirq_cfg_reg;
  logic [1:0] waitcfg_reg;
  pwr_state_e state_reg;
  pwr_state_e state_next;
  pwr_req_e req_reg;
  logic req_nmi_low_reg;
  logic req_powerdown_config_bit_reg;
  logic refused_reg;
  logic woke_reg;
  logic resume_reg;
  logic [3:0] cause_reg;
  logic rtc_lp_reg;
  logic ready_seen_reg;
  logic ready_ok_reg;
  logic [2:0] fast_cnt_reg [NUM_FAST_IRQ];
  logic [31:0] prdata_reg;

  // apb decode
  logic apb_wr;
  logic apb_rd_setup;
  logic addr_hit;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == SYSCFG_OFFSET) || (a == MISC_OFFSET) ||
      (a == FASTIRQ_OFFSET) || (a == WAITCFG_OFFSET) || (a == STATUS_OFFSET);
  endfunction

  assign addr_hit = is_mapped(paddr);
  assign apb_wr = psel && penable && pwrite && addr_hit && clk_en;
  assign apb_rd_setup = psel && !penable && !pwrite && clk_en;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_reg;

  // fast interrupt levels: pol bit 1 means active high
  logic [NUM_FAST_IRQ-1:0] fast_en;
  logic [NUM_FAST_IRQ-1:0] fast_active;
  logic fast_wake;
  logic powerdown_config_bit;

  assign fast_en = fastirq_cfg_reg[FAST_EN_LSB +: NUM_FAST_IRQ];
  assign fast_active = fast_en & ~(fast_s ^ fastirq_cfg_reg[FAST_POL_LSB +: NUM_FAST_IRQ]);
  assign powerdown_config_bit = system_config_register_reg[POWERDOWN_CONFIG_BIT_BIT];

  // wake from a fast input only after it stood active long enough
  always_comb
  begin
    fast_wake = 1'b0;
    for (int i = 0; i < NUM_FAST_IRQ; i++)
    begin
      if (fast_cnt_reg[i] >= WAKE_MIN_CYC)
      begin
        fast_wake = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_FAST_IRQ; i++)
      begin
        fast_cnt_reg[i] <= 3'h0;
      end
    end
    else if (clk_en)
    begin
      for (int i = 0; i < NUM_FAST_IRQ; i++)
      begin
        if (!fast_active[i])
        begin
          fast_cnt_reg[i] <= 3'h0;
        end
        else if (fast_cnt_reg[i] < WAKE_MIN_CYC)
        begin
          fast_cnt_reg[i] <= fast_cnt_reg[i] + 3'h1;
        end
      end
    end
  end

  // ready handshake seen at its polarity during the last bus access
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_seen_reg <= 1'b0;
      ready_ok_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      if (bus_access_done)
      begin
        ready_ok_reg <= ready_seen_reg || (ready_s == waitcfg_reg[WAIT_POL_BIT]);
        ready_seen_reg <= 1'b0;
      end
      else if (bus_access_active && (ready_s == waitcfg_reg[WAIT_POL_BIT]))
      begin
        ready_seen_reg <= 1'b1;
      end
    end
  end

  // entry checks once the bus has drained
  logic entry_ok;
  logic any_pd_wake;

  always_comb
  begin
    entry_ok = !waitcfg_reg[WAIT_EN_BIT] || ready_ok_reg;
    if (req_reg == REQ_PD)
    begin
      if (!req_powerdown_config_bit_reg)
      begin
        entry_ok = entry_ok && req_nmi_low_reg;
      end
      else
      begin
        entry_ok = entry_ok && (fast_active == '0);
      end
    end
  end

  assign any_pd_wake = fast_wake || rtc_irq || can_i2c_irq || !rstpin_s_n;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (idle_instr || clock_stop_instruction)
        begin
          state_next = ST_DRAIN;
        end
      end
      ST_DRAIN:
      begin
        if (!bus_pending)
        begin
          if (!entry_ok)
          begin
            state_next = ST_RUN;
          end
          else if (req_reg == REQ_IDLE)
          begin
            state_next = ST_IDLE;
          end
          else if (req_powerdown_config_bit_reg)
          begin
            state_next = ST_PD_INT;
          end
          else
          begin
            state_next = ST_PD_PROT;
          end
        end
      end
      ST_IDLE:
      begin
        if (irq_request || !rstpin_s_n)
        begin
          state_next = ST_RUN;
        end
      end
      ST_PD_PROT:
      begin
        if (!rstpin_s_n)
        begin
          state_next = ST_RUN;
        end
      end
      ST_PD_INT:
      begin
        if (any_pd_wake)
        begin
          state_next = ST_RUN;
        end
      end
      default:
      begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_RUN;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // capture request kind, nmi level and mode selection at the instruction
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_reg <= REQ_NONE;
      req_nmi_low_reg <= 1'b0;
      req_powerdown_config_bit_reg <= 1'b0;
    end
    else if (clk_en && state_reg == ST_RUN)
    begin
      if (clock_stop_instruction)
      begin
        req_reg <= REQ_PD;
        req_nmi_low_reg <= !nmi_s_n;
        req_powerdown_config_bit_reg <= powerdown_config_bit;
      end
      else if (idle_instr)
      begin
        req_reg <= REQ_IDLE;
      end
    end
  end

  // status: refusal, wake, resume and cause; set wins over clear
  logic st_clr_refused;
  logic st_clr_woke;
  logic refuse_evt;
  logic wake_evt;
  logic [3:0] wake_cause;

  assign st_clr_refused = apb_wr && paddr == STATUS_OFFSET && pwdata[ST_REFUSED_BIT];
  assign st_clr_woke = apb_wr && paddr == STATUS_OFFSET && pwdata[ST_WOKE_BIT];
  assign refuse_evt = clk_en && state_reg == ST_DRAIN && !bus_pending && !entry_ok;
  assign wake_evt = clk_en && state_next == ST_RUN &&
    (state_reg == ST_IDLE || state_reg == ST_PD_PROT || state_reg == ST_PD_INT);

  always_comb
  begin
    if (!rstpin_s_n)
    begin
      wake_cause = CAUSE_RESET_PIN;
    end
    else if (state_reg == ST_IDLE)
    begin
      wake_cause = CAUSE_IRQ;
    end
    else if (fast_wake)
    begin
      wake_cause = CAUSE_FAST;
    end
    else if (rtc_irq)
    begin
      wake_cause = CAUSE_RTC;
    end
    else
    begin
      wake_cause = CAUSE_CAN_I2C;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refused_reg <= 1'b0;
      woke_reg <= 1'b0;
      cause_reg <= CAUSE_NONE;
    end
    else
    begin
      if (refuse_evt)
      begin
        refused_reg <= 1'b1;
      end
      else if (st_clr_refused)
      begin
        refused_reg <= 1'b0;
      end
      if (wake_evt)
      begin
        woke_reg <= 1'b1;
        cause_reg <= wake_cause;
      end
      else if (st_clr_woke)
      begin
        woke_reg <= 1'b0;
      end
    end
  end

  // after idle wake, cpu continues past the halt once the handler returns
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resume_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_reg == ST_IDLE && state_next == ST_RUN)
      begin
        resume_reg <= 1'b1;
      end
      else if (return_from_interrupt)
      begin
        resume_reg <= 1'b0;
      end
    end
  end

  // rtc reference follows the low-power oscillator once it is seen
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rtc_lp_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (misc_control_register_reg[LPOSC_DIS_BIT])
      begin
        rtc_lp_reg <= 1'b0;
      end
      else if (lposc_s)
      begin
        rtc_lp_reg <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      system_config_register_reg <= SYSCFG_RESET;
      misc_control_register_reg <= MISC_RESET;
      fastirq_cfg_reg <= FASTIRQ_RESET;
      waitcfg_reg <= WAITCFG_RESET;
    end
    else if (apb_wr)
    begin
      case (paddr)
        SYSCFG_OFFSET: system_config_register_reg <= pwdata[7:0];
        MISC_OFFSET: misc_control_register_reg <= pwdata[2:0];
        FASTIRQ_OFFSET: fastirq_cfg_reg <= pwdata[15:0];
        WAITCFG_OFFSET: waitcfg_reg <= pwdata[1:0];
        default:
        begin
        end
      endcase
    end
  end

  // read data registered in the setup phase
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (apb_rd_setup)
    begin
      prdata_reg <= 32'h0000_0000;
      case (paddr)
        SYSCFG_OFFSET: prdata_reg[7:0] <= system_config_register_reg;
        MISC_OFFSET: prdata_reg[2:0] <= misc_control_register_reg;
        FASTIRQ_OFFSET: prdata_reg[15:0] <= fastirq_cfg_reg;
        WAITCFG_OFFSET: prdata_reg[1:0] <= waitcfg_reg;
        STATUS_OFFSET:
        begin
          prdata_reg[ST_MODE_LSB +: 3] <= state_reg;
          prdata_reg[ST_RTC_LP_BIT] <= rtc_lp_reg;
          prdata_reg[ST_REFUSED_BIT] <= refused_reg;
          prdata_reg[ST_WOKE_BIT] <= woke_reg;
          prdata_reg[ST_RESUME_BIT] <= resume_reg;
          prdata_reg[ST_CAUSE_LSB +: 4] <= cause_reg;
        end
        default:
        begin
        end
      endcase
    end
  end

  // power control outputs
  logic in_pd;

  assign in_pd = state_reg == ST_PD_PROT || state_reg == ST_PD_INT;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_halt <= 1'b0;
      periph_clk_stop <= 1'b0;
      wdt_hold <= 1'b0;
      main_osc_stop <= 1'b0;
      regulator_off <= 1'b0;
      pd_wake <= 1'b0;
    end
    else if (clk_en)
    begin
      cpu_halt <= state_next == ST_IDLE || state_next == ST_PD_PROT ||
        state_next == ST_PD_INT;
      periph_clk_stop <= state_next == ST_PD_PROT || state_next == ST_PD_INT;
      wdt_hold <= state_next == ST_PD_PROT || state_next == ST_PD_INT;
      // main osc kept for rtc unless the low-power oscillator serves it
      main_osc_stop <= (state_next == ST_PD_PROT || state_next == ST_PD_INT) &&
        (rtc_lp_reg || !misc_control_register_reg[RTC_EN_BIT]);
      regulator_off <= in_pd && misc_control_register_reg[REGOFF_BIT];
      pd_wake <= in_pd && state_next == ST_RUN;
    end
  end

  assign rtc_ref_lp = rtc_lp_reg;
endmodule
`default_nettype wire

/* pwr_mode_pkg.sv */
// constants and types for the power reduction mode controller
`default_nettype none
package pwr_mode_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WAKE_MIN_NS = 40;
  localparam int unsigned WAKE_MIN_CYC_I = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] WAKE_MIN_CYC = 3'(WAKE_MIN_CYC_I);
  localparam int unsigned NUM_FAST_IRQ = 8;

  localparam logic [7:0] SYSCFG_OFFSET = 8'h00;
  localparam logic [7:0] MISC_OFFSET = 8'h04;
  localparam logic [7:0] FASTIRQ_OFFSET = 8'h08;
  localparam logic [7:0] WAITCFG_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;

  localparam int unsigned POWERDOWN_CONFIG_BIT_BIT = 5;
  localparam int unsigned REGOFF_BIT = 0;
  localparam int unsigned RTC_EN_BIT = 1;
  localparam int unsigned LPOSC_DIS_BIT = 2;
  localparam int unsigned FAST_EN_LSB = 0;
  localparam int unsigned FAST_POL_LSB = 8;
  localparam int unsigned WAIT_EN_BIT = 0;
  localparam int unsigned WAIT_POL_BIT = 1;
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_RTC_LP_BIT = 4;
  localparam int unsigned ST_REFUSED_BIT = 5;
  localparam int unsigned ST_WOKE_BIT = 6;
  localparam int unsigned ST_RESUME_BIT = 7;
  localparam int unsigned ST_CAUSE_LSB = 8;

  localparam logic [7:0] SYSCFG_RESET = 8'h00;
  localparam logic [2:0] MISC_RESET = 3'h0;
  localparam logic [15:0] FASTIRQ_RESET = 16'h0000;
  localparam logic [1:0] WAITCFG_RESET = 2'h0;

  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_IRQ = 4'h1;
  localparam logic [3:0] CAUSE_FAST = 4'h2;
  localparam logic [3:0] CAUSE_RTC = 4'h3;
  localparam logic [3:0] CAUSE_CAN_I2C = 4'h4;
  localparam logic [3:0] CAUSE_RESET_PIN = 4'h5;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DRAIN,
    ST_IDLE,
    ST_PD_PROT,
    ST_PD_INT
  } pwr_state_e;

  typedef enum logic [1:0] {
    REQ_NONE,
    REQ_IDLE,
    REQ_PD
  } pwr_req_e;
endpackage
`default_nettype wire

/* pin_sync.sv */
// two flip-flop synchroniser for asynchronous pin inputs
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= INIT;
      sync_out <= INIT;
    end
    else if (clk_en)
    begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

/* pwr_mode_ctrl_chk.sv */
// concurrent checks on the power mode controller ports
`default_nettype none
module pwr_mode_ctrl_chk
  import pwr_mode_pkg::*;
(
  // clock, reset and apb writes
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // cpu, bus and pins
  input wire logic idle_instr,
  input wire logic clock_stop_instruction,
  input wire logic irq_request,
  input wire logic rtc_irq,
  input wire logic bus_pending,
  input wire logic reset_input_pin_n,
  input wire logic lp_osc_running,
  // power outputs
  input wire logic cpu_halt,
  input wire logic periph_clk_stop,
  input wire logic wdt_hold,
  input wire logic main_osc_stop,
  input wire logic rtc_ref_lp,
  input wire logic pd_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_en;
  logic int_cfg_reg;
  logic [2:0] misc_reg;
  logic instr_reg;
  assign wr_en = psel && penable && pwrite && clk_en;
  // shadow of mode and misc settings
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      {int_cfg_reg, misc_reg} <= 4'h0;
    else if (wr_en && paddr == SYSCFG_OFFSET)
      int_cfg_reg <= pwdata[POWERDOWN_CONFIG_BIT_BIT];
    else if (wr_en && paddr == MISC_OFFSET)
      misc_reg <= pwdata[2:0];
  end
  // instruction seen, dropped once the bus has drained
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      instr_reg <= 1'b0;
    else if (idle_instr || clock_stop_instruction)
      instr_reg <= 1'b1;
    else if (!bus_pending)
      instr_reg <= 1'b0;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_pins_quiet;
    reset_input_pin_n [*4];
  endsequence
  sequence s_wake_once;
    $past(periph_clk_stop) ##1 !pd_wake;
  endsequence
  property p_drain; $rose(cpu_halt) |-> !$past(bus_pending); endproperty
  a_drain: assert property (p_drain)
    else $error("halt entered with bus pending");
  property p_instr; $rose(cpu_halt) |-> $past(instr_reg); endproperty
  a_instr: assert property (p_instr)
    else $error("halt without instruction");
  property p_pd_hold; periph_clk_stop |-> cpu_halt && wdt_hold; endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("power down without cpu and watchdog hold");
  property p_idle_wake;
    clk_en && cpu_halt && !periph_clk_stop && irq_request |-> ##[1:3] !cpu_halt;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle not left on interrupt");
  property p_prot_hold; s_pins_quiet ##0 (periph_clk_stop && !int_cfg_reg) |=> periph_clk_stop;
  endproperty
  a_prot_hold: assert property (p_prot_hold)
    else $error("protected power down left without reset pin");
  property p_rtc_wake; periph_clk_stop && int_cfg_reg && rtc_irq |-> ##[1:3] !periph_clk_stop;
  endproperty
  a_rtc_wake: assert property (p_rtc_wake)
    else $error("rtc interrupt did not wake");
  property p_osc_stop; periph_clk_stop && rtc_ref_lp |-> main_osc_stop; endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("main oscillator kept with low-power reference");
  property p_osc_keep; periph_clk_stop && !rtc_ref_lp && misc_reg[RTC_EN_BIT] |-> !main_osc_stop;
  endproperty
  a_osc_keep: assert property (p_osc_keep)
    else $error("main oscillator stopped while rtc needs it");
  property p_lp_adopt; $rose(lp_osc_running) && !misc_reg[LPOSC_DIS_BIT] |-> ##[1:5] rtc_ref_lp;
  endproperty
  a_lp_adopt: assert property (p_lp_adopt)
    else $error("low-power oscillator not adopted");
  property p_wake; pd_wake |-> s_wake_once; endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse outside power down exit");
  property p_wake_pulse; $fell(periph_clk_stop) |-> pd_wake; endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("power down exit without wake pulse");
endmodule
bind pwr_mode_ctrl pwr_mode_ctrl_chk pwr_mode_ctrl_chk_i (.clk_sys, .rst_n, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .idle_instr, .clock_stop_instruction, .irq_request,
  .rtc_irq, .bus_pending, .reset_input_pin_n, .lp_osc_running, .cpu_halt, .periph_clk_stop,
  .wdt_hold, .main_osc_stop, .rtc_ref_lp, .pd_wake);
`default_nettype wire

/* pwr_pins_model.sv */
// reset, nmi and fast interrupt pins outside the device
`default_nettype none
module pwr_pins_model (
  // clock
  input wire logic clk_sys,
  // pins
  output logic reset_input_pin_n,
  output logic nmi_pin_n,
  output logic [pwr_mode_pkg::NUM_FAST_IRQ-1:0] fast_external_interrupt_input
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_mode_pkg::*;
  initial
  begin
    reset_input_pin_n = 1'b1;
    nmi_pin_n = 1'b1;
    fast_external_interrupt_input = '1;
  end
  // reset held long enough for clocks to settle
  task automatic pin_reset(input int n);
    @(posedge clk_sys);
    reset_input_pin_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    reset_input_pin_n <= 1'b1;
  endtask
  task automatic set_nmi(input logic v);
    @(posedge clk_sys);
    nmi_pin_n <= v;
  endtask
  task automatic set_fast(input logic [NUM_FAST_IRQ-1:0] v);
    @(posedge clk_sys);
    fast_external_interrupt_input <= v;
  endtask
  // active low wake pulse of n cycles
  task automatic fast_wake(input int idx, input int n);
    @(posedge clk_sys);
    fast_external_interrupt_input[idx] <= 1'b0;
    repeat (n) @(posedge clk_sys);
    fast_external_interrupt_input[idx] <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the power mode controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_mode_pkg::*;
  logic clk_sys, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic idle_instr, clock_stop_instruction, return_from_interrupt, irq_request, rtc_irq;
  logic can_i2c_irq, bus_pending, bus_access_active, bus_access_done, ready_pin;
  logic nmi_pin_n, reset_input_pin_n, lp_osc_running, cpu_halt, periph_clk_stop, wdt_hold;
  logic main_osc_stop, rtc_ref_lp, regulator_off, pd_wake;
  logic [NUM_FAST_IRQ-1:0] fast_external_interrupt_input;
  int error_cnt, n_checks;
  pwr_mode_ctrl pwr_mode_ctrl_i (.clk_sys, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .idle_instr, .clock_stop_instruction,
    .return_from_interrupt, .irq_request, .rtc_irq, .can_i2c_irq, .bus_pending,
    .bus_access_active, .bus_access_done, .ready_pin, .nmi_pin_n, .reset_input_pin_n,
    .fast_external_interrupt_input, .lp_osc_running, .cpu_halt, .periph_clk_stop, .wdt_hold,
    .main_osc_stop, .rtc_ref_lp, .regulator_off, .pd_wake);
  pwr_pins_model pwr_pins_model_i (.clk_sys, .reset_input_pin_n, .nmi_pin_n,
    .fast_external_interrupt_input);
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // setup, access until pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata & m);
  endtask
  task automatic enter(input logic pd);
    if (pd)
      clock_stop_instruction <= 1'b1;
    else
      idle_instr <= 1'b1;
    @(posedge clk_sys);
    clock_stop_instruction <= 1'b0;
    idle_instr <= 1'b0;
    cyc(3);
  endtask
  task automatic irq_pulse;
    irq_request <= 1'b1;
    cyc(1);
    irq_request <= 1'b0;
    cyc(2);
  endtask
  task automatic access(input logic rdy);
    ready_pin <= rdy;
    bus_access_active <= 1'b1;
    cyc(4);
    bus_access_done <= 1'b1;
    cyc(1);
    {bus_access_active, bus_access_done} <= 2'h0;
    cyc(3);
  endtask
  task automatic s_regs;
    logic [7:0] offs [5];
    offs = '{SYSCFG_OFFSET, MISC_OFFSET, FASTIRQ_OFFSET, WAITCFG_OFFSET, STATUS_OFFSET};
    foreach (offs[i])
      rd("reset value", offs[i], 32'hffffffff, 32'h0);
    apb(1'b1, 8'h14, 32'hffffffff);
    chb("unmapped error", 1'b1, rerr);
    rd("unmapped data", 8'h14, 32'hffffffff, 32'h0);
  endtask
  task automatic s_idle;
    bus_pending <= 1'b1;
    enter(1'b0);
    chb("halt while draining", 1'b0, cpu_halt);
    rd("mode drain", STATUS_OFFSET, 32'h7, 32'h1);
    bus_pending <= 1'b0;
    cyc(2);
    chb("idle halt", 1'b1, cpu_halt);
    chb("idle periph", 1'b0, periph_clk_stop);
    clk_en <= 1'b0;
    irq_pulse();
    chb("frozen idle", 1'b1, cpu_halt);
    clk_en <= 1'b1;
    irq_pulse();
    chb("idle end", 1'b0, cpu_halt);
    rd("resume pending", STATUS_OFFSET, 32'h87, 32'h80);
    return_from_interrupt <= 1'b1;
    cyc(1);
    return_from_interrupt <= 1'b0;
    rd("resumed", STATUS_OFFSET, 32'h87, 32'h0);
  endtask
  task automatic s_wait;
    apb(1'b1, WAITCFG_OFFSET, 32'h3);
    access(1'b0);
    enter(1'b0);
    chb("wait refused", 1'b0, cpu_halt);
    rd("refused flag", STATUS_OFFSET, 32'h27, 32'h20);
    apb(1'b1, STATUS_OFFSET, 32'h20);
    access(1'b1);
    enter(1'b0);
    chb("wait seen", 1'b1, cpu_halt);
    irq_pulse();
    apb(1'b1, WAITCFG_OFFSET, 32'h0);
  endtask
  task automatic s_prot;
    apb(1'b1, MISC_OFFSET, 32'h3);
    apb(1'b1, FASTIRQ_OFFSET, 32'h1);
    apb(1'b1, SYSCFG_OFFSET, 32'h0);
    enter(1'b1);
    chb("nmi high refused", 1'b0, periph_clk_stop);
    pwr_pins_model_i.set_nmi(1'b0);
    cyc(3);
    enter(1'b1);
    rd("mode protected", STATUS_OFFSET, 32'h7, 32'h3);
    chb("clock held", 1'b1, wdt_hold);
    chb("main osc kept", 1'b0, main_osc_stop);
    chb("regulator off", 1'b1, regulator_off);
    {rtc_irq, can_i2c_irq} <= 2'h3;
    pwr_pins_model_i.fast_wake(0, 6);
    {rtc_irq, can_i2c_irq} <= 2'h0;
    cyc(4);
    chb("protected kept", 1'b1, periph_clk_stop);
    pwr_pins_model_i.pin_reset(6);
    cyc(3);
    chb("reset pin wake", 1'b0, periph_clk_stop);
    rd("wake cause", STATUS_OFFSET, 32'hf47, {20'h0, CAUSE_RESET_PIN, 8'h40});
    pwr_pins_model_i.set_nmi(1'b1);
    apb(1'b1, STATUS_OFFSET, 32'h60);
  endtask
  task automatic s_int;
    logic [3:0] cause [3];
    cause = '{CAUSE_FAST, CAUSE_RTC, CAUSE_CAN_I2C};
    lp_osc_running <= 1'b1;
    cyc(6);
    chb("low-power ref", 1'b1, rtc_ref_lp);
    apb(1'b1, SYSCFG_OFFSET, 32'h20);
    pwr_pins_model_i.set_fast(8'hfe);
    cyc(3);
    enter(1'b1);
    chb("fast active refused", 1'b0, periph_clk_stop);
    pwr_pins_model_i.set_fast(8'hff);
    cyc(3);
    foreach (cause[k])
    begin
      enter(1'b1);
      rd("mode interruptible", STATUS_OFFSET, 32'h7, 32'h4);
      chb("main osc stopped", 1'b1, main_osc_stop);
      if (k == 0)
        pwr_pins_model_i.fast_wake(0, 5);
      else
        {rtc_irq, can_i2c_irq} <= (k == 1) ? 2'h2 : 2'h1;
      cyc(10);
      {rtc_irq, can_i2c_irq} <= 2'h0;
      chb("woken", 1'b0, periph_clk_stop);
      rd("cause", STATUS_OFFSET, 32'hf00, {20'h0, cause[k], 8'h0});
    end
    apb(1'b1, MISC_OFFSET, 32'h7);
    cyc(3);
    chb("low-power ref off", 1'b0, rtc_ref_lp);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(20000);
    error_cnt++;
    summarize();
  end
  initial
  begin
    {error_cnt, n_checks} = '0;
    {rst_n, psel, penable, pwrite, paddr, pwdata, idle_instr, clock_stop_instruction} = '0;
    {return_from_interrupt, irq_request, rtc_irq, can_i2c_irq, bus_pending} = '0;
    {bus_access_active, bus_access_done, ready_pin, lp_osc_running} = '0;
    clk_en = 1'b1;
    cyc(3);
    rst_n <= 1'b1;
    cyc(4);
    s_regs();
    s_idle();
    s_wait();
    s_prot();
    s_int();
    summarize();
  end
endmodule
`default_nettype wire
